// File: src/acs_pkg.sv
// package of register map, field layout and timing constants for the converter config block
package acs_pkg;

  // ==========================================================================
  // register map
  localparam int ACS_ADDR_W = 8; // register pointer width
  localparam int ACS_DATA_W = 16; // register width
  localparam logic [7:0] ACS_REG_CONV_CFG = 8'h01; // converter_configuration
  localparam logic [7:0] ACS_REG_SHUNT_CAL = 8'h02; // shunt_calibration
  localparam logic [15:0] ACS_CONV_CFG_RST = 16'hFB68; // converter_configuration reset
  localparam logic [15:0] ACS_SHUNT_CAL_RST = 16'h1000; // shunt_calibration reset
  localparam logic [15:0] ACS_RD_ZERO = 16'h0000; // unmapped or reserved read value

  // ==========================================================================
  // field positions
  localparam int ACS_MODE_HI = 15; // operating mode
  localparam int ACS_MODE_LO = 12;
  localparam int ACS_MODE_CONT = 15; // continuous bit of mode
  localparam int ACS_BCT_HI = 11; // bus_voltage_conv_time
  localparam int ACS_BCT_LO = 9;
  localparam int ACS_SCT_HI = 8; // shunt_voltage_conv_time
  localparam int ACS_SCT_LO = 6;
  localparam int ACS_TCT_HI = 5; // temperature_conv_time
  localparam int ACS_TCT_LO = 3;
  localparam int ACS_AVG_HI = 2; // sample_averaging_count
  localparam int ACS_AVG_LO = 0;
  localparam int ACS_CAL_HI = 14; // calibration constant, bit 15 reads zero

  // ==========================================================================
  // channel indices, fixed conversion order bus, shunt, temperature
  localparam logic [1:0] ACS_CH_BUS = 2'h0;
  localparam logic [1:0] ACS_CH_SHUNT = 2'h1;
  localparam logic [1:0] ACS_CH_TEMP = 2'h2;
  localparam logic [1:0] ACS_CH_NONE = 2'h3; // no further channel selected

  // ==========================================================================
  // timing
  localparam int ACS_CLK_HZ = 125_000_000; // clock rate
  localparam int ACS_TICK_NS = 1000; // base tick of 1 us
  localparam int ACS_CYC_PER_TICK = (ACS_CLK_HZ / 1_000_000) * ACS_TICK_NS / 1000;
  localparam int ACS_DLY_STEP_MS = 2; // initial conversion delay step
  localparam int ACS_DLY_STEP_US = ACS_DLY_STEP_MS * 1000; // step in ticks
  localparam int ACS_US_W = 19; // holds 510000 us
  localparam int ACS_ACC_W = 26; // 16-bit sample plus 1024 accumulations
  localparam int ACS_CUR_SHIFT = 11; // current scaling shift after calibration product
  localparam int ACS_CNT_W = 11; // sample counter, up to 1024

  // conversion time per code, in microseconds
  localparam logic [12:0] ACS_CT_US [8] = '{13'h0032, 13'h0054, 13'h0096, 13'h0118,
                                            13'h021C, 13'h041C, 13'h081A, 13'h1018};
  // averaging count as a power of two
  localparam logic [3:0] ACS_AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                               4'h7, 4'h8, 4'h9, 4'hA};

  // sequencer states
  typedef enum logic [1:0] {ACS_IDLE, ACS_DELAY, ACS_CONV} acs_state_t;

endpackage

// File: src/acs_tick_div.sv
// clock divider that gives a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
module acs_tick_div #(
  parameter int DIV = 125 // cycles per pulse
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic clr_i, // restart the period
  output logic tick_o // one-cycle enable pulse
);
  localparam int CW = $clog2(DIV); // counter width
  localparam logic [CW-1:0] LAST = CW'(DIV - 1); // final count

  logic [CW-1:0] cnt_r; // cycle counter
  logic [CW-1:0] cnt_nxt;

  // ==========================================================================
  // next count
  always_comb begin
    cnt_nxt = cnt_r + CW'(1);
    if (clr_i || cnt_r == LAST) begin
      cnt_nxt = '0;
    end
  end

  // register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_o = (cnt_r == LAST) && !clr_i;

endmodule

// File: src/acs_conv_ctrl.sv
// converter configuration registers, conversion sequencer and current scaling
//
// Function
// - mode bits 15-12, reset Fh, 0h/8h shutdown
// - codes 1h-7h: one triggered pass, bits select channels
// - codes 9h-Fh: continuous conversion of selected channels
// - bus conversion time bits 11-9, eight durations
// - shunt conversion time bits 8-6, same durations
// - temperature conversion time bits 5-3, same durations
// - averaging bits 2-0, 1 to 1024 samples
// - result updates only after full averaging run
// - 15-bit calibration constant, reset 1000h
// - calibration sets current result weight
// - calibration bit 15 reads zero
// - initial conversion delay in 2 ms steps
// - current result is 16-bit two's complement
`timescale 1ns/1ps
module acs_conv_ctrl
  import acs_pkg::*;
(
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [acs_pkg::ACS_ADDR_W-1:0] reg_addr_i, // register pointer from serial port
  input wire logic [acs_pkg::ACS_DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic reg_rd_i, // read strobe, one cycle
  output logic [acs_pkg::ACS_DATA_W-1:0] reg_rdata_o, // read data, valid cycle after strobe
  input wire logic [7:0] init_conv_delay_i, // initial_conversion_delay code
  input wire logic signed [15:0] bus_sample_i, // bus voltage modulator sample
  input wire logic signed [15:0] shunt_sample_i, // shunt voltage modulator sample
  input wire logic signed [15:0] temp_sample_i, // temperature modulator sample
  output logic [1:0] conv_chan_o, // channel being converted
  output logic converting_o, // a channel conversion is in progress
  output logic pass_done_o, // pulse at end of a pass over selected channels
  output logic signed [15:0] bus_result_o, // averaged bus voltage
  output logic signed [15:0] shunt_result_o, // averaged shunt voltage
  output logic signed [15:0] temp_result_o, // averaged temperature
  output logic signed [15:0] current_result_o // calculated current
);
  import acs_pkg::*;

  localparam logic [ACS_US_W-1:0] US_ONE = ACS_US_W'(1); // one tick
  localparam logic [ACS_CNT_W-1:0] CNT_ONE = ACS_CNT_W'(1); // one sample

  // ==========================================================================
  // state
  logic [15:0] cfg_r, cfg_nxt; // converter_configuration
  logic [15:0] cal_r, cal_nxt; // shunt_calibration
  logic [15:0] rdata_r, rdata_nxt; // read data
  acs_state_t state_r, state_nxt; // sequencer state
  logic [1:0] chan_r, chan_nxt; // active channel
  logic [ACS_US_W-1:0] us_r, us_nxt; // elapsed microseconds in interval
  logic [ACS_CNT_W-1:0] samp_r, samp_nxt; // samples taken for channel
  logic signed [ACS_ACC_W-1:0] acc_r, acc_nxt; // averaging accumulator
  logic signed [15:0] bus_r, bus_nxt; // bus result
  logic signed [15:0] shunt_r, shunt_nxt; // shunt result
  logic signed [15:0] temp_r, temp_nxt; // temperature result
  logic signed [15:0] cur_r, cur_nxt; // current result
  logic done_r, done_nxt; // pass complete pulse

  // ==========================================================================
  // helpers
  logic tick; // 1 us enable
  logic tick_clr; // restart the divider with a new interval
  logic [3:0] mode; // mode in force
  logic [2:0] avg_code; // averaging code
  logic [2:0] ct_code; // conversion time code of active channel
  logic [ACS_US_W-1:0] dly_us; // initial delay in microseconds
  logic [ACS_CNT_W-1:0] avg_last; // final sample index
  logic signed [15:0] samp_in; // sample of active channel
  logic signed [ACS_ACC_W-1:0] acc_sum; // accumulator plus new sample
  logic signed [15:0] avg_val; // averaged result
  logic signed [31:0] cur_prod; // shunt times calibration
  logic signed [31:0] cur_scl; // scaled current before saturation
  logic [1:0] next_ch; // next selected channel after active one
  logic [1:0] first_ch; // first selected channel of a pass

  // finds the lowest selected channel at or above a start index
  function automatic logic [1:0] find_chan(input logic [2:0] sel, input logic [2:0] from);
    logic [1:0] res;
    res = ACS_CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (sel[i] && 3'(i) >= from) begin
        res = 2'(i);
      end
    end
    return res;
  endfunction

  // 1 us timebase
  acs_tick_div #(
    .DIV(ACS_CYC_PER_TICK)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(tick_clr),
    .tick_o(tick)
  );

  // ==========================================================================
  // datapath terms
  always_comb begin
    mode = cfg_r[ACS_MODE_HI:ACS_MODE_LO];
    avg_code = cfg_r[ACS_AVG_HI:ACS_AVG_LO];
    avg_last = (CNT_ONE << ACS_AVG_SHIFT[avg_code]) - CNT_ONE;
    dly_us = ACS_US_W'(init_conv_delay_i) * ACS_US_W'(ACS_DLY_STEP_US);
    case (chan_r)
      ACS_CH_BUS: begin
        ct_code = cfg_r[ACS_BCT_HI:ACS_BCT_LO];
        samp_in = bus_sample_i;
      end
      ACS_CH_SHUNT: begin
        ct_code = cfg_r[ACS_SCT_HI:ACS_SCT_LO];
        samp_in = shunt_sample_i;
      end
      default: begin
        ct_code = cfg_r[ACS_TCT_HI:ACS_TCT_LO];
        samp_in = temp_sample_i;
      end
    endcase
    acc_sum = acc_r + ACS_ACC_W'(samp_in);
    avg_val = 16'(acc_sum >>> ACS_AVG_SHIFT[avg_code]);
    // calibration constant scales and sets the weight of the current result
    cur_prod = 32'(avg_val) * 32'(signed'({1'b0, cal_r[ACS_CAL_HI:0]}));
    cur_scl = cur_prod >>> ACS_CUR_SHIFT;
    next_ch = find_chan(mode[2:0], 3'(chan_r) + 3'h1);
    first_ch = find_chan(mode[2:0], 3'h0);
  end

  // ==========================================================================
  // registers and sequencer, next values
  always_comb begin
    cfg_nxt = cfg_r;
    cal_nxt = cal_r;
    rdata_nxt = rdata_r;
    state_nxt = state_r;
    chan_nxt = chan_r;
    us_nxt = us_r;
    samp_nxt = samp_r;
    acc_nxt = acc_r;
    bus_nxt = bus_r;
    shunt_nxt = shunt_r;
    temp_nxt = temp_r;
    cur_nxt = cur_r;
    done_nxt = 1'b0;
    tick_clr = 1'b0;
    // register reads, unmapped pointers read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        ACS_REG_CONV_CFG: rdata_nxt = cfg_r;
        ACS_REG_SHUNT_CAL: rdata_nxt = {1'b0, cal_r[ACS_CAL_HI:0]};
        default: rdata_nxt = ACS_RD_ZERO;
      endcase
    end
    if (reg_wr_i && reg_addr_i == ACS_REG_SHUNT_CAL) begin
      cal_nxt = {1'b0, reg_wdata_i[ACS_CAL_HI:0]};
    end
    if (reg_wr_i && reg_addr_i == ACS_REG_CONV_CFG) begin
      // a configuration write aborts any pass and re-arms the sequence, or idles it when the new mode is shutdown
      cfg_nxt = reg_wdata_i;
      us_nxt = '0;
      tick_clr = 1'b1;
      if (reg_wdata_i[ACS_MODE_LO+2:ACS_MODE_LO] == 3'h0) begin
        state_nxt = ACS_IDLE;
      end else begin
        state_nxt = ACS_DELAY;
      end
    end else begin
      case (state_r)
        ACS_IDLE: begin
          // shutdown, or triggered pass already finished
        end
        ACS_DELAY: begin
          if (tick) begin
            us_nxt = us_r + US_ONE;
          end
          if (dly_us == '0 || (tick && us_r + US_ONE >= dly_us)) begin
            state_nxt = ACS_CONV;
            chan_nxt = first_ch;
            us_nxt = '0;
            samp_nxt = '0;
            acc_nxt = '0;
            tick_clr = 1'b1;
          end
        end
        ACS_CONV: begin
          if (tick) begin
            us_nxt = us_r + US_ONE;
            if (us_r + US_ONE >= ACS_US_W'(ACS_CT_US[ct_code])) begin
              us_nxt = '0;
              acc_nxt = acc_sum;
              samp_nxt = samp_r + CNT_ONE;
              if (samp_r == avg_last) begin
                // averaging run done for this channel
                acc_nxt = '0;
                samp_nxt = '0;
                case (chan_r)
                  ACS_CH_BUS: bus_nxt = avg_val;
                  ACS_CH_SHUNT: begin
                    shunt_nxt = avg_val;
                    if (cur_scl > 32'sh00007FFF) begin
                      cur_nxt = 16'sh7FFF;
                    end else if (cur_scl < -32'sh00008000) begin
                      cur_nxt = 16'sh8000;
                    end else begin
                      cur_nxt = 16'(cur_scl);
                    end
                  end
                  default: temp_nxt = avg_val;
                endcase
                if (next_ch != ACS_CH_NONE) begin
                  chan_nxt = next_ch;
                end else begin
                  done_nxt = 1'b1;
                  if (mode[3]) begin
                    chan_nxt = first_ch;
                  end else begin
                    state_nxt = ACS_IDLE;
                  end
                end
              end
            end
          end
        end
        default: state_nxt = ACS_IDLE;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= ACS_CONV_CFG_RST;
      cal_r <= ACS_SHUNT_CAL_RST;
      rdata_r <= ACS_RD_ZERO;
      state_r <= ACS_DELAY; // reset mode is continuous, so start after the delay
      chan_r <= ACS_CH_BUS;
      us_r <= '0;
      samp_r <= '0;
      acc_r <= '0;
      bus_r <= '0;
      shunt_r <= '0;
      temp_r <= '0;
      cur_r <= '0;
      done_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      cal_r <= cal_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      us_r <= us_nxt;
      samp_r <= samp_nxt;
      acc_r <= acc_nxt;
      bus_r <= bus_nxt;
      shunt_r <= shunt_nxt;
      temp_r <= temp_nxt;
      cur_r <= cur_nxt;
      done_r <= done_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_o = rdata_r;
  assign conv_chan_o = chan_r;
  assign converting_o = (state_r == ACS_CONV);
  assign pass_done_o = done_r;
  assign bus_result_o = bus_r;
  assign shunt_result_o = shunt_r;
  assign temp_result_o = temp_r;
  assign current_result_o = cur_r;

endmodule

// File: verif/acs_monitor.sv
// checker of register port and sequencer behaviour at the top ports
`timescale 1ns/1ps
module acs_monitor
  import acs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [7:0] reg_addr_i, // register pointer
  input wire logic [15:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [15:0] reg_rdata_o, // read data
  input wire logic [1:0] conv_chan_o, // active channel
  input wire logic converting_o, // conversion busy
  input wire logic pass_done_o, // end of pass
  input wire logic signed [15:0] bus_result_o, // bus result
  input wire logic signed [15:0] shunt_result_o, // shunt result
  input wire logic signed [15:0] current_result_o // current result
);
  // ==========================================================================
  // mode tracking
  logic [3:0] mode_r; // last written mode
  logic [3:0] mode_nxt; // next mode
  // follow config writes
  always_comb begin
    mode_nxt = mode_r;
    if (reg_wr_i && reg_addr_i == ACS_REG_CONV_CFG) begin
      mode_nxt = reg_wdata_i[15:12];
    end
  end
  // register mode
  always_ff @(posedge clk_i) begin
    mode_r <= rst_i ? 4'hF : mode_nxt;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_zero;
    reg_rd_i && reg_addr_i != ACS_REG_CONV_CFG && reg_addr_i != ACS_REG_SHUNT_CAL
      |=> reg_rdata_o == ACS_RD_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  property p_cal_b15;
    reg_rd_i && reg_addr_i == ACS_REG_SHUNT_CAL |=> !reg_rdata_o[15];
  endproperty
  a_cal_b15: assert property (p_cal_b15) else $error("calibration bit 15 set");
  property p_rd_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_pulse;
    pass_done_o |=> !pass_done_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pass done longer than one cycle");
  property p_shut;
    reg_wr_i && reg_addr_i == ACS_REG_CONV_CFG && reg_wdata_i[14:12] == 3'h0
      |-> ##2 !converting_o [*8];
  endproperty
  a_shut: assert property (p_shut) else $error("conversion in shutdown");
  property p_bus_upd;
    $changed(bus_result_o) |-> $past(converting_o) && $past(conv_chan_o) == ACS_CH_BUS;
  endproperty
  a_bus_upd: assert property (p_bus_upd) else $error("bus result moved off run end");
  property p_sh_upd;
    $changed(shunt_result_o) |-> $past(converting_o) && $past(conv_chan_o) == ACS_CH_SHUNT;
  endproperty
  a_sh_upd: assert property (p_sh_upd) else $error("shunt result moved off run end");
  property p_cur_upd;
    $changed(current_result_o) |-> $past(conv_chan_o) == ACS_CH_SHUNT;
  endproperty
  a_cur_upd: assert property (p_cur_upd) else $error("current moved off shunt run");
  property p_trig_idle;
    pass_done_o && !mode_r[3] |=> !converting_o [*8];
  endproperty
  a_trig_idle: assert property (p_trig_idle) else $error("triggered pass repeated");
  property p_cont;
    pass_done_o && mode_r[3] |-> ##[0:3] converting_o;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous pass not repeated");
  c_trig: cover property (pass_done_o && !mode_r[3]);
  c_cont: cover property (pass_done_o && mode_r[3]);
  c_unmap: cover property (reg_rd_i && reg_addr_i == 8'h03);
endmodule
bind acs_conv_ctrl acs_monitor u_mon (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .conv_chan_o, .converting_o, .pass_done_o, .bus_result_o,
  .shunt_result_o, .current_result_o);

// File: verif/acs_host_model.sv
// host side model issuing register writes and reads
`timescale 1ns/1ps
module acs_host_model (
  input wire logic clk_i, // clock
  input wire logic [15:0] rdata_i, // read data from block
  output logic [7:0] addr_o, // register pointer
  output logic [15:0] wdata_o, // write data
  output logic wr_o, // write strobe
  output logic rd_o // read strobe
);
  // idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // one-cycle read, data taken once settled
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule

// File: verif/tb.sv
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
module tb;
  import acs_pkg::*;
  logic clk_i = 1'b0; // clock
  logic rst_i = 1'b1; // reset
  logic [7:0] addr; // register pointer
  logic [15:0] wdata, rdata; // register data
  logic wr, rd, conv, done; // strobes and status
  logic [1:0] chan; // active channel
  logic signed [15:0] bus_s = 16'sh0000, sh_s = 16'sh0000, tm_s = 16'sh0000; // sample sources
  logic signed [15:0] bres, sres, tres, cres; // results
  int bad_count = 0, num_checks = 0, cyc; // counters
  logic [15:0] seqv; // packed channel order
  logic [7:0] dly = 8'h00; // initial conversion delay code
  always #4 clk_i = ~clk_i;
  acs_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  acs_conv_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .init_conv_delay_i(dly),
    .bus_sample_i(bus_s), .shunt_sample_i(sh_s), .temp_sample_i(tm_s), .conv_chan_o(chan),
    .converting_o(conv), .pass_done_o(done), .bus_result_o(bres), .shunt_result_o(sres),
    .temp_result_o(tres), .current_result_o(cres));
  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
    logic [15:0] d;
    host.rd(a, d);
    chk(n, e, d);
  endtask
  // wait for end of pass, packing each new channel as a nibble
  task automatic wait_pass(input int lim);
    cyc = 0;
    do begin
      @(posedge clk_i);
      #1 cyc++;
      if (conv === 1'b1 && (seqv[3:0] !== {2'h0, chan} + 4'h1)) begin
        seqv = {seqv[11:0], 2'h0, chan} + 16'h1;
      end
    end while (done !== 1'b1 && cyc < lim);
    chk("pass_done_o", 16'h0001, {15'h0, done});
  endtask
  task automatic set_s(input logic [15:0] b, input logic [15:0] s, input logic [15:0] t);
    @(posedge clk_i);
    bus_s <= b;
    sh_s <= s;
    tm_s <= t;
  endtask
  // converting_o must stay low for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1 if (conv !== 1'b0) seen = 1'b1;
    end
    chk("converting_o idle", 16'h0000, {15'h0, seen});
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rdc(ACS_REG_CONV_CFG, 16'hFB68, "config reset");
    rdc(ACS_REG_SHUNT_CAL, 16'h1000, "cal reset");
    rdc(8'h03, 16'h0000, "unmapped read");
    host.wr(ACS_REG_SHUNT_CAL, 16'hFFFF);
    rdc(ACS_REG_SHUNT_CAL, 16'h7FFF, "cal bit 15");
    host.wr(8'h03, 16'h1234);
    host.wr(ACS_REG_SHUNT_CAL, 16'h1000);
    rdc(ACS_REG_SHUNT_CAL, 16'h1000, "cal write");
    rdc(ACS_REG_CONV_CFG, 16'hFB68, "config after stray write");
    $display("test t_regs done");
  endtask
  task automatic t_trig();
    set_s(16'h1234, 16'h0100, 16'h0321);
    host.wr(ACS_REG_CONV_CFG, 16'h7040);
    seqv = 16'h0;
    wait_pass(30000);
    chk_rng("pass length", 23000, 23030, cyc);
    chk("channel order", 16'h0123, seqv);
    chk("bus result", 16'h1234, bres);
    chk("shunt result", 16'h0100, sres);
    chk("temp result", 16'h0321, tres);
    chk("current", 16'h0200, cres);
    quiet(300);
    rdc(ACS_REG_CONV_CFG, 16'h7040, "config readback");
    $display("test t_trig done");
  endtask
  task automatic t_avg();
    set_s(16'h1234, 16'hFF00, 16'h0321);
    host.wr(ACS_REG_CONV_CFG, 16'h2001);
    repeat (7000) @(posedge clk_i);
    #1 chk("shunt mid run", 16'h0100, sres);
    wait_pass(20000);
    chk_rng("avg run length", 25000, 25030, cyc + 7000);
    chk("shunt averaged", 16'hFF00, sres);
    chk("negative current", 16'hFE00, cres);
    chk("bus untouched", 16'h1234, bres);
    quiet(300);
    $display("test t_avg done");
  endtask
  task automatic t_cont();
    set_s(16'h0055, 16'h0100, 16'h0321);
    host.wr(ACS_REG_CONV_CFG, 16'hB000);
    seqv = 16'h0;
    wait_pass(14000);
    wait_pass(14000);
    // the wrap back to bus already shows on each done edge
    chk("continuous order", 16'h2121, seqv);
    host.wr(ACS_REG_SHUNT_CAL, 16'h0800);
    wait_pass(14000);
    chk("rescaled current", 16'h0100, cres);
    chk("bus continuous", 16'h0055, bres);
    $display("test t_cont done");
  endtask
  task automatic t_shut();
    @(posedge clk_i);
    dly <= 8'h01;
    host.wr(ACS_REG_CONV_CFG, 16'h9000);
    // a 2 ms delay step must hold off the first conversion
    quiet(1000);
    host.wr(ACS_REG_CONV_CFG, 16'h8000);
    repeat (2) @(posedge clk_i);
    quiet(1000);
    host.wr(ACS_REG_CONV_CFG, 16'h0000);
    repeat (2) @(posedge clk_i);
    quiet(500);
    $display("test t_shut done");
  endtask
  // ==========================================================================
  // verdict and run control
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_trig();
    t_avg();
    t_cont();
    t_shut();
    summarize();
  end
  // watchdog
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
